// *** shared/usbb_pkg.sv ***
package usbb_pkg;

   // ****************************************
   // register word offsets (bit 8 selects packet memory)
   // ****************************************
   localparam logic [8:0] OFS_CONTROL    = 9'h000;
   localparam logic [8:0] OFS_INT_STATUS = 9'h001;
   localparam logic [8:0] OFS_DEV_ADDR   = 9'h002;
   localparam logic [8:0] OFS_TABLE_BASE = 9'h003;
   localparam logic [8:0] OFS_EP_FIRST   = 9'h008;
   localparam int         PM_SEL_BIT     = 8;

   // ****************************************
   // field positions and reset values
   // ****************************************
   localparam int         CTL_FORCE_RESET_BIT = 0;
   localparam int         CTL_POWER_DOWN_BIT  = 1;
   localparam logic [1:0] CTL_RESET_VALUE     = 2'h3;
   localparam int         IST_BUS_RESET_BIT   = 0;
   localparam int         IST_XFER_BIT        = 1;
   localparam int         DA_ENABLE_BIT       = 7;
   localparam int         TB_ALIGN_BITS       = 3;

   localparam int         EP_W            = 9;
   localparam int         EP_STAT_RX_LSB  = 0;
   localparam int         EP_STAT_TX_LSB  = 2;
   localparam int         ENDPOINT_TYPE_FIELD_LSB     = 4;
   localparam int         ENDPOINT_KIND_BIT_BIT     = 6;
   localparam int         EP_CTR_RX_BIT   = 7;
   localparam int         EP_CTR_TX_BIT   = 8;
   localparam logic [1:0] STAT_DISABLED   = 2'h0;
   localparam logic [1:0] STAT_STALL      = 2'h1;
   localparam logic [1:0] STAT_NAK        = 2'h2;
   localparam logic [1:0] STAT_VALID      = 2'h3;

   // ****************************************
   // descriptor table layout
   // ****************************************
   localparam logic [1:0] SLOT_TX_ADDR   = 2'h0;
   localparam logic [1:0] SLOT_TX_COUNT  = 2'h1;
   localparam logic [1:0] SLOT_RX_ADDR   = 2'h2;
   localparam logic [1:0] SLOT_RX_COUNT  = 2'h3;
   localparam int         CNT_BLSIZE_BIT = 15;
   localparam int         CNT_NBLK_LSB   = 10;
   localparam int         CRC_BYTES      = 2;

   // ****************************************
   // memory and clocks
   // ****************************************
   localparam int NUM_EP          = 8;
   localparam int PM_WORDS        = 256;
   localparam int PM_WIDTH        = 16;
   localparam int SYS_CLK_MHZ     = 50;
   localparam int USB_CLK_MHZ     = 48;
   localparam int MIN_BUS_CLK_MHZ = 8;

   typedef enum logic [5:0] {
      ST_IDLE   = 6'b000001,
      ST_DESC_A = 6'b000010,
      ST_DESC_C = 6'b000100,
      ST_RUN    = 6'b001000,
      ST_FLUSH  = 6'b010000,
      ST_WBACK  = 6'b100000
   } usbb_state_t;

endpackage

// *** verilog/usbb_pkt_mem.sv ***
`timescale 1ns/10ps
module usbb_pkt_mem #(
   parameter int WORDS = 256,
   parameter int WIDTH = 16,
   parameter int AW    = 8
) (
   input  wire logic             i_clk,
   input  wire logic             i_a_we,
   input  wire logic [AW-1:0]    i_a_addr,
   input  wire logic [WIDTH-1:0] i_a_wdata,
   output logic      [WIDTH-1:0] o_a_rdata,
   input  wire logic             i_b_we,
   input  wire logic [AW-1:0]    i_b_addr,
   input  wire logic [WIDTH-1:0] i_b_wdata,
   output logic      [WIDTH-1:0] o_b_rdata
);

   logic [WIDTH-1:0] mem [WORDS];

   // ****************************************
   // dual-port store: processor port and usb port, both written on the same edge
   // ****************************************
   // [RQ7] processor half first
   always_ff @(posedge i_clk) begin
      if (i_a_we) begin
         mem[i_a_addr] <= i_a_wdata;
      end
      if (i_b_we) begin
         mem[i_b_addr] <= i_b_wdata;
      end
   end

   assign o_a_rdata = mem[i_a_addr];
   assign o_b_rdata = mem[i_b_addr];

endmodule

// *** verilog/usbb_buffer_setup.sv ***
// Behaviour
// [RQ1] software enables clocks, releases reset first
// [RQ2] power on, wait, release reset, clear status
// [RQ3] bus reset disables every endpoint
// [RQ4] software enables function, address zero, endpoint zero
// [RQ5] assigned address goes in bits 6:0
// [RQ6] software re-enables endpoint zero within 10 ms
// [RQ7] memory split between processor and usb
// [RQ8] usb logic on its own 48 MHz clock (here it shares i_clk with the processor side)
// [RQ9] bus clock kept above 8 MHz
// [RQ10] two buffers per endpoint, anywhere
// [RQ11] table at base, 8-byte aligned
// [RQ12] unidirectional endpoints use one buffer
// [RQ13] buffers filled from lowest address
// [RQ14] never write beyond allocated buffer
// [RQ15] software sets up transmit side
// [RQ16] software sets up receive side
// [RQ17] hardware updates entries while enabled
// [RQ18] system reset setup then bus reset flow
// [RQ19] eight endpoint registers
// [RQ20] 256 by 16 packet memory
// [RQ21] entry: tx addr, tx count, rx addr, rx count
`timescale 1ns/10ps
module usbb_buffer_setup
   import usbb_pkg::*;
#(
   parameter int N_EP = NUM_EP
) (
   input  wire logic       i_clk,
   input  wire logic       i_rst,
   input  wire logic [8:0] i_addr,
   input  wire logic [15:0] i_wdata,
   input  wire logic       i_wr,
   input  wire logic       i_rd,
   output logic      [15:0] o_rdata,
   input  wire logic       i_bus_reset,
   input  wire logic       i_xfer_start,
   input  wire logic [2:0] i_xfer_ep,
   input  wire logic       i_xfer_rx,
   input  wire logic       i_rx_valid,
   input  wire logic [7:0] i_rx_data,
   input  wire logic       i_tx_ready,
   input  wire logic       i_pkt_end,
   input  wire logic       i_pkt_ok,
   output logic            o_tx_valid,
   output logic      [7:0] o_tx_data,
   output logic            o_xfer_done,
   output logic            o_reply_ack,
   output logic            o_reply_nak,
   output logic            o_reply_stall,
   output logic            o_transceiver_power_down,
   output logic            o_force_peripheral_reset,
   output logic            o_function_enable,
   output logic      [6:0] o_device_address
);

   // ****************************************
   // helpers
   // ****************************************
   // [RQ11] base plus entry, three low bits zero
   function automatic logic [7:0] desc_word(input logic [15:0] base, input logic [2:0] ep,
                                            input logic [1:0] slot);
      desc_word = base[8:1] + {3'h0, ep, 2'h0} + {6'h0, slot};
   endfunction

   function automatic logic [10:0] rx_capacity(input logic [15:0] cnt);
      if (cnt[CNT_BLSIZE_BIT]) begin
         rx_capacity = {1'b0, {5'h00, cnt[CNT_NBLK_LSB +: 5]} + 10'h001} << 5;
      end else begin
         rx_capacity = {5'h00, cnt[CNT_NBLK_LSB +: 5], 1'b0};
      end
   endfunction

   // ****************************************
   // state
   // ****************************************
   usbb_state_t         state_reg;
   logic [1:0]          control_reg;
   logic [1:0]          istat_reg;
   logic [7:0]          daddr_reg;
   logic [15:0]         table_base_reg;
   logic [EP_W-1:0]     ep_reg [N_EP];
   logic [15:0]         rdata_reg;
   logic [2:0]          ep_sel_reg;
   logic                rx_dir_reg;
   logic [7:0]          ptr_reg;
   logic [15:0]         cnt_entry_reg;
   logic [10:0]         idx_reg;
   logic [7:0]          lo_reg;
   logic                ok_reg;
   logic                tx_valid_reg;
   logic [7:0]          tx_data_reg;
   logic                done_reg;
   logic                ack_reg;
   logic                nak_reg;
   logic                stall_reg;
   logic                ctr_rx_set;
   logic                ctr_tx_set;

   logic                pm_sel;
   logic                a_we;
   logic [15:0]         a_rdata;
   logic                b_we;
   logic [7:0]          b_addr;
   logic [15:0]         b_wdata;
   logic [15:0]         b_rdata;
   logic [10:0]         cap;
   logic                overrun;
   logic                abort;
   logic [1:0]          sel_stat;

   assign pm_sel   = i_addr[PM_SEL_BIT];
   assign a_we     = i_wr & pm_sel;
   assign cap      = rx_capacity(cnt_entry_reg);
   assign overrun  = {1'b0, idx_reg} > ({1'b0, cap} + 12'(CRC_BYTES));
   assign abort    = i_bus_reset | control_reg[CTL_FORCE_RESET_BIT];
   // [RQ12] own direction only
   assign sel_stat = i_xfer_rx ? ep_reg[i_xfer_ep][EP_STAT_RX_LSB +: 2]
                               : ep_reg[i_xfer_ep][EP_STAT_TX_LSB +: 2];

   // [RQ20] shared packet store
   usbb_pkt_mem #(
      .WORDS (PM_WORDS),
      .WIDTH (PM_WIDTH),
      .AW    (8)
   ) u_mem (
      .i_clk     (i_clk),
      .i_a_we    (a_we),
      .i_a_addr  (i_addr[7:0]),
      .i_a_wdata (i_wdata),
      .o_a_rdata (a_rdata),
      .i_b_we    (b_we),
      .i_b_addr  (b_addr),
      .i_b_wdata (b_wdata),
      .o_b_rdata (b_rdata)
   );

   // ****************************************
   // usb side memory port
   // ****************************************
   always_comb begin
      b_we    = 1'b0;
      b_addr  = ptr_reg + idx_reg[8:1];
      b_wdata = {i_rx_data, lo_reg};
      case (state_reg)
         // [RQ21] slot order
         ST_DESC_A: begin
            b_addr = desc_word(table_base_reg, ep_sel_reg, rx_dir_reg ? SLOT_RX_ADDR
                                                                      : SLOT_TX_ADDR);
         end
         ST_DESC_C: begin
            b_addr = desc_word(table_base_reg, ep_sel_reg, rx_dir_reg ? SLOT_RX_COUNT
                                                                      : SLOT_TX_COUNT);
         end
         ST_RUN: begin
            // [RQ14] words past capacity are dropped
            b_we = rx_dir_reg & i_rx_valid & idx_reg[0] & (idx_reg < cap);
         end
         ST_FLUSH: begin
            b_we    = idx_reg[0] & (idx_reg <= cap);
            b_wdata = {8'h00, lo_reg};
         end
         ST_WBACK: begin
            // [RQ17] count entry rewritten, size fields kept
            b_we    = 1'b1;
            b_addr  = desc_word(table_base_reg, ep_sel_reg, SLOT_RX_COUNT);
            b_wdata = {cnt_entry_reg[15:10], idx_reg[9:0] - 10'(CRC_BYTES)};
         end
         default: begin
            b_we = 1'b0;
         end
      endcase
   end

   // ****************************************
   // transfer engine
   // ****************************************
   always_ff @(posedge i_clk) begin
      done_reg   <= 1'b0;
      ack_reg    <= 1'b0;
      nak_reg    <= 1'b0;
      stall_reg  <= 1'b0;
      ctr_rx_set <= 1'b0;
      ctr_tx_set <= 1'b0;
      if (i_rst || abort) begin
         state_reg     <= ST_IDLE;
         ep_sel_reg    <= 3'h0;
         rx_dir_reg    <= 1'b0;
         ptr_reg       <= 8'h00;
         cnt_entry_reg <= 16'h0000;
         idx_reg       <= 11'h000;
         lo_reg        <= 8'h00;
         ok_reg        <= 1'b0;
         tx_valid_reg  <= 1'b0;
         tx_data_reg   <= 8'h00;
      end else begin
         case (state_reg)
            ST_IDLE: begin
               if (i_xfer_start && daddr_reg[DA_ENABLE_BIT]) begin
                  ep_sel_reg <= i_xfer_ep;
                  rx_dir_reg <= i_xfer_rx;
                  idx_reg    <= 11'h000;
                  if (sel_stat == STAT_VALID) begin
                     state_reg <= ST_DESC_A;
                  end else if (sel_stat != STAT_DISABLED) begin
                     done_reg  <= 1'b1;
                     nak_reg   <= (sel_stat == STAT_NAK);
                     stall_reg <= (sel_stat == STAT_STALL);
                  end
               end
            end
            ST_DESC_A: begin
               // [RQ10] buffer may sit anywhere
               ptr_reg   <= b_rdata[8:1];
               state_reg <= ST_DESC_C;
            end
            ST_DESC_C: begin
               cnt_entry_reg <= b_rdata;
               state_reg     <= ST_RUN;
            end
            ST_RUN: begin
               // [RQ13] bytes walk up from the bottom
               if (rx_dir_reg && i_rx_valid) begin
                  if (!idx_reg[0]) begin
                     lo_reg <= i_rx_data;
                  end
                  if (idx_reg != 11'h7ff) begin
                     idx_reg <= idx_reg + 11'h001;
                  end
               end
               if (!rx_dir_reg && (!tx_valid_reg || i_tx_ready)) begin
                  if (idx_reg < {1'b0, cnt_entry_reg[9:0]}) begin
                     tx_data_reg  <= idx_reg[0] ? b_rdata[15:8] : b_rdata[7:0];
                     tx_valid_reg <= 1'b1;
                     idx_reg      <= idx_reg + 11'h001;
                  end else begin
                     tx_valid_reg <= 1'b0;
                  end
               end
               if (i_pkt_end) begin
                  tx_valid_reg <= 1'b0;
                  ok_reg       <= i_pkt_ok;
                  if (rx_dir_reg) begin
                     state_reg <= ST_FLUSH;
                  end else begin
                     state_reg  <= ST_IDLE;
                     done_reg   <= 1'b1;
                     ctr_tx_set <= i_pkt_ok;
                  end
               end
            end
            ST_FLUSH: begin
               if (ok_reg && !overrun && idx_reg >= 11'(CRC_BYTES)) begin
                  state_reg <= ST_WBACK;
               end else begin
                  state_reg <= ST_IDLE;
                  done_reg  <= 1'b1;
                  stall_reg <= ok_reg & overrun;
               end
            end
            ST_WBACK: begin
               state_reg  <= ST_IDLE;
               done_reg   <= 1'b1;
               ack_reg    <= 1'b1;
               ctr_rx_set <= 1'b1;
            end
            default: begin
               state_reg <= ST_IDLE;
            end
         endcase
      end
   end

   // ****************************************
   // endpoint registers
   // ****************************************
   // [RQ19] one register per endpoint pair
   always_ff @(posedge i_clk) begin
      for (int e = 0; e < N_EP; e++) begin
         if (i_rst || control_reg[CTL_FORCE_RESET_BIT]) begin
            ep_reg[e] <= '0;
         end else if (i_bus_reset) begin
            // [RQ3] all communication disabled
            ep_reg[e][EP_STAT_RX_LSB +: 2] <= STAT_DISABLED;
            ep_reg[e][EP_STAT_TX_LSB +: 2] <= STAT_DISABLED;
         end else begin
            if (i_wr && !pm_sel && i_addr == OFS_EP_FIRST + 9'(e)) begin
               ep_reg[e][ENDPOINT_KIND_BIT_BIT:0]  <= i_wdata[ENDPOINT_KIND_BIT_BIT:0];
               ep_reg[e][EP_CTR_RX_BIT]  <= ep_reg[e][EP_CTR_RX_BIT] & i_wdata[EP_CTR_RX_BIT];
               ep_reg[e][EP_CTR_TX_BIT]  <= ep_reg[e][EP_CTR_TX_BIT] & i_wdata[EP_CTR_TX_BIT];
            end
            // [RQ17] completion sets flag, parks on nak
            if (ctr_rx_set && ep_sel_reg == 3'(e)) begin
               ep_reg[e][EP_CTR_RX_BIT]        <= 1'b1;
               ep_reg[e][EP_STAT_RX_LSB +: 2]  <= STAT_NAK;
            end
            if (ctr_tx_set && ep_sel_reg == 3'(e)) begin
               ep_reg[e][EP_CTR_TX_BIT]        <= 1'b1;
               ep_reg[e][EP_STAT_TX_LSB +: 2]  <= STAT_NAK;
            end
         end
      end
   end

   // ****************************************
   // global registers
   // ****************************************
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         control_reg    <= CTL_RESET_VALUE;
         daddr_reg      <= 8'h00;
         table_base_reg <= 16'h0000;
      end else if (i_wr && !pm_sel) begin
         case (i_addr)
            OFS_CONTROL:    control_reg <= i_wdata[1:0];
            // [RQ5] address in low seven bits
            OFS_DEV_ADDR:   daddr_reg <= i_wdata[7:0];
            // [RQ11] low bits forced to zero
            OFS_TABLE_BASE: table_base_reg <= {i_wdata[15:TB_ALIGN_BITS], 3'h0};
            default: ;
         endcase
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         istat_reg <= 2'h0;
      end else begin
         if (i_wr && !pm_sel && i_addr == OFS_INT_STATUS) begin
            istat_reg <= istat_reg & i_wdata[1:0];
         end
         if (i_bus_reset) begin
            istat_reg[IST_BUS_RESET_BIT] <= 1'b1;
         end
         if (ctr_rx_set || ctr_tx_set) begin
            istat_reg[IST_XFER_BIT] <= 1'b1;
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         rdata_reg <= 16'h0000;
      end else if (i_rd) begin
         if (pm_sel) begin
            rdata_reg <= a_rdata;
         end else if (i_addr >= OFS_EP_FIRST && i_addr < OFS_EP_FIRST + 9'(N_EP)) begin
            rdata_reg <= {7'h00, ep_reg[i_addr[2:0]]};
         end else begin
            case (i_addr)
               OFS_CONTROL:    rdata_reg <= {14'h0000, control_reg};
               OFS_INT_STATUS: rdata_reg <= {14'h0000, istat_reg};
               OFS_DEV_ADDR:   rdata_reg <= {8'h00, daddr_reg};
               OFS_TABLE_BASE: rdata_reg <= table_base_reg;
               default:        rdata_reg <= 16'h0000;
            endcase
         end
      end else begin
         rdata_reg <= 16'h0000;
      end
   end

   assign o_rdata                  = rdata_reg;
   assign o_tx_valid               = tx_valid_reg;
   assign o_tx_data                = tx_data_reg;
   assign o_xfer_done              = done_reg;
   assign o_reply_ack              = ack_reg;
   assign o_reply_nak              = nak_reg;
   assign o_reply_stall            = stall_reg;
   assign o_transceiver_power_down = control_reg[CTL_POWER_DOWN_BIT];
   assign o_force_peripheral_reset = control_reg[CTL_FORCE_RESET_BIT];
   assign o_function_enable        = daddr_reg[DA_ENABLE_BIT];
   assign o_device_address         = daddr_reg[6:0];

endmodule

// *** testbench/usbb_assertions.sv ***
`timescale 1ns/10ps
module usbb_checker
   import usbb_pkg::*;
(
   input wire logic        i_clk,
   input wire logic        i_rst,
   input wire logic [8:0]  i_addr,
   input wire logic [15:0] i_wdata,
   input wire logic        i_wr,
   input wire logic        i_rd,
   input wire logic [15:0] o_rdata,
   input wire logic        i_bus_reset,
   input wire logic        i_xfer_start,
   input wire logic        i_tx_ready,
   input wire logic        i_pkt_end,
   input wire logic        o_tx_valid,
   input wire logic [7:0]  o_tx_data,
   input wire logic        o_xfer_done,
   input wire logic        o_reply_ack,
   input wire logic        o_reply_nak,
   input wire logic        o_reply_stall,
   input wire logic        o_transceiver_power_down,
   input wire logic        o_force_peripheral_reset,
   input wire logic        o_function_enable,
   input wire logic [6:0]  o_device_address
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_rst);
   wire logic [2:0] rep = {o_reply_ack, o_reply_nak, o_reply_stall};

   chk_reset_ctl: assert property (disable iff (1'b0) i_rst |=>
      o_transceiver_power_down && o_force_peripheral_reset && !o_function_enable)
      else $error("control not at reset value");
   chk_ctl_write: assert property (i_wr && i_addr == OFS_CONTROL |=>
      o_force_peripheral_reset == $past(i_wdata[0])
      && o_transceiver_power_down == $past(i_wdata[1])) else $error("control write lost");
   chk_addr_write: assert property (i_wr && i_addr == OFS_DEV_ADDR |=>
      o_device_address == $past(i_wdata[6:0])
      && o_function_enable == $past(i_wdata[7])) else $error("address write lost");
   chk_pm_readback: assert property (i_wr && i_addr[8] ##1
      i_rd && i_addr == $past(i_addr) |=> o_rdata == $past(i_wdata, 2))
      else $error("readback wrong");
   chk_base_align: assert property (i_rd && i_addr == OFS_TABLE_BASE |=>
      o_rdata[2:0] == 3'h0) else $error("table base not aligned");
   chk_reply_one: assert property (rep != 3'h0 |->
      o_xfer_done && $onehot(rep)) else $error("reply without single done");
   chk_done_pulse: assert property (o_xfer_done |=> !o_xfer_done)
      else $error("done longer than one cycle");
   chk_tx_hold: assert property (o_tx_valid && !i_tx_ready && !i_pkt_end
      && !i_bus_reset && !o_force_peripheral_reset |=> o_tx_valid
      && $stable(o_tx_data)) else $error("tx byte dropped");
   chk_off_silent: assert property (i_xfer_start && !o_function_enable |=>
      !o_xfer_done [*4]) else $error("answer while function off");
   chk_bus_abort: assert property (i_bus_reset |=> ##[0:1] !o_tx_valid)
      else $error("tx continues after bus reset");

   cov_ack: cover property (o_reply_ack);
   cov_nak: cover property (o_reply_nak);
   cov_stall: cover property (o_reply_stall);
endmodule

bind usbb_buffer_setup usbb_checker u_chk (.i_clk, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd,
   .o_rdata, .i_bus_reset, .i_xfer_start, .i_tx_ready, .i_pkt_end, .o_tx_valid, .o_tx_data,
   .o_xfer_done, .o_reply_ack, .o_reply_nak, .o_reply_stall, .o_transceiver_power_down,
   .o_force_peripheral_reset, .o_function_enable, .o_device_address);

// *** testbench/usbb_host_model.sv ***
`timescale 1ns/10ps
module usbb_host_model (
   input  wire logic       i_clk,
   input  wire logic       i_tx_valid,
   input  wire logic [7:0] i_tx_data,
   input  wire logic       i_done,
   input  wire logic [2:0] i_reply,
   output logic            o_bus_reset,
   output logic            o_start,
   output logic [2:0]      o_ep,
   output logic            o_dir_rx,
   output logic            o_rx_valid,
   output logic [7:0]      o_rx_data,
   output logic            o_tx_ready,
   output logic            o_pkt_end,
   output logic            o_pkt_ok
);
   logic [2:0] rep = 3'h0;
   logic [7:0] got [8];
   initial begin
      {o_bus_reset, o_start, o_ep, o_dir_rx, o_rx_valid, o_tx_ready} = '0;
      {o_pkt_end, o_pkt_ok, o_rx_data} = '0;
   end
   // last handshake seen: ack, nak, stall
   always @(posedge i_clk) if (i_done) rep <= i_reply;

   task automatic bus_reset;
      @(posedge i_clk);
      o_bus_reset <= 1'b1;
      @(posedge i_clk);
      o_bus_reset <= 1'b0;
   endtask
   task automatic token(input logic [2:0] ep, input logic rx);
      rep = 3'h0;
      @(posedge i_clk);
      o_start <= 1'b1;
      o_ep <= ep;
      o_dir_rx <= rx;
      @(posedge i_clk);
      o_start <= 1'b0;
      repeat (2) @(posedge i_clk);
   endtask
   task automatic finish_pkt(input logic ok);
      o_pkt_end <= 1'b1;
      o_pkt_ok <= ok;
      o_tx_ready <= 1'b0;
      @(posedge i_clk);
      o_pkt_end <= 1'b0;
      o_pkt_ok <= 1'b0;
      repeat (5) @(posedge i_clk);
   endtask
   // bytes 0x10 up, inverted between
   task automatic out_pkt(input logic [2:0] ep, input int n, input logic ok);
      token(ep, 1'b1);
      for (int i = 0; i < n; i++) begin
         o_rx_valid <= 1'b1;
         o_rx_data <= 8'h10 + 8'(i);
         @(posedge i_clk);
         o_rx_valid <= 1'b0;
         o_rx_data <= ~(8'h10 + 8'(i));
         @(posedge i_clk);
      end
      finish_pkt(ok);
   endtask
   // stalls every third cycle
   task automatic in_pkt(input logic [2:0] ep, input int n);
      int c = 0;
      token(ep, 1'b0);
      for (int k = 0; k < 40 && c < n; k++) begin
         o_tx_ready <= (k % 3 != 2);
         @(posedge i_clk);
         if (i_tx_valid && o_tx_ready) begin
            got[c] = i_tx_data;
            c++;
         end
      end
      finish_pkt(1'b1);
   endtask
endmodule

// *** testbench/test_usbb_buffer_setup.sv ***
`timescale 1ns/10ps
module test_usbb_buffer_setup;
   import usbb_pkg::*;
   logic        i_clk = 1'b0;
   logic        i_rst = 1'b1;
   logic [8:0]  i_addr = 9'h0;
   logic [15:0] i_wdata = 16'h0;
   logic        i_wr = 1'b0;
   logic        i_rd = 1'b0;
   logic [15:0] o_rdata;
   logic        i_bus_reset, i_xfer_start, i_xfer_rx, i_rx_valid, i_tx_ready, i_pkt_end;
   logic        i_pkt_ok, o_tx_valid, o_xfer_done, o_reply_ack, o_reply_nak, o_reply_stall;
   logic        o_transceiver_power_down, o_force_peripheral_reset, o_function_enable;
   logic [2:0]  i_xfer_ep;
   logic [7:0]  i_rx_data, o_tx_data;
   logic [6:0]  o_device_address;
   int          fails = 0;
   int          total_checks = 0;

   always #10 i_clk = ~i_clk;

   usbb_buffer_setup DUT (.i_clk, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
      .i_bus_reset, .i_xfer_start, .i_xfer_ep, .i_xfer_rx, .i_rx_valid, .i_rx_data,
      .i_tx_ready, .i_pkt_end, .i_pkt_ok, .o_tx_valid, .o_tx_data, .o_xfer_done,
      .o_reply_ack, .o_reply_nak, .o_reply_stall, .o_transceiver_power_down,
      .o_force_peripheral_reset, .o_function_enable, .o_device_address);
   usbb_host_model host (.i_clk, .i_tx_valid(o_tx_valid), .i_tx_data(o_tx_data),
      .i_done(o_xfer_done), .i_reply({o_reply_ack, o_reply_nak, o_reply_stall}),
      .o_bus_reset(i_bus_reset), .o_start(i_xfer_start), .o_ep(i_xfer_ep),
      .o_dir_rx(i_xfer_rx), .o_rx_valid(i_rx_valid), .o_rx_data(i_rx_data),
      .o_tx_ready(i_tx_ready), .o_pkt_end(i_pkt_end), .o_pkt_ok(i_pkt_ok));

   // *****************
   // bus and compare
   // *****************
   task automatic wr(input logic [8:0] a, input logic [15:0] d);
      @(posedge i_clk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_clk);
      i_wr <= 1'b0;
   endtask
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      total_checks++;
      if (g !== e) begin
         $display("mismatch %s expected %h seen %h", n, e, g);
         fails++;
      end
   endtask
   task automatic rd_now(input logic [8:0] a, input logic [15:0] e);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_clk);
      i_rd <= 1'b0;
      @(negedge i_clk);
      chk($sformatf("word %h", a), e, o_rdata);
   endtask
   task automatic rdchk(input logic [8:0] a, input logic [15:0] e);
      @(posedge i_clk);
      rd_now(a, e);
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // *****************
   // scenarios
   // *****************
   task automatic t_bringup;
      @(negedge i_clk);
      chk("power_down", 16'h1, 16'(o_transceiver_power_down));
      rdchk(OFS_CONTROL, 16'h0003);
      rdchk(9'h004, 16'h0000);
      rdchk(9'h00f, 16'h0000);
      host.out_pkt(3'h0, 2, 1'b1);
      chk("reply while off", 16'h0, 16'(host.rep));
      wr(OFS_CONTROL, 16'h0001);
      @(negedge i_clk);
      chk("power_down", 16'h0, 16'(o_transceiver_power_down));
      repeat (8) @(posedge i_clk);
      wr(OFS_CONTROL, 16'h0000);
      wr(OFS_INT_STATUS, 16'h0000);
      rdchk(OFS_INT_STATUS, 16'h0000);
      wr(OFS_DEV_ADDR, 16'h0080);
      @(negedge i_clk);
      chk("force_reset", 16'h0, 16'(o_force_peripheral_reset));
      chk("function_enable", 16'h1, 16'(o_function_enable));
      wr(OFS_TABLE_BASE, 16'h0047);
      rdchk(OFS_TABLE_BASE, 16'h0040);
      wr(9'h1ff, 16'ha5c3);
      rd_now(9'h1ff, 16'ha5c3);
      $display("bring-up test done");
   endtask
   task automatic t_rx;
      wr(9'h122, 16'h0080);
      wr(9'h123, 16'h0800);
      wr(9'h142, 16'hbeef);
      wr(OFS_EP_FIRST, 16'h0003);
      host.out_pkt(3'h0, 6, 1'b1);
      chk("rx reply", 16'h4, 16'(host.rep));
      rdchk(9'h140, 16'h1110);
      rdchk(9'h141, 16'h1312);
      rdchk(9'h142, 16'hbeef);
      rdchk(9'h123, 16'h0804);
      rdchk(OFS_EP_FIRST, 16'h0082);
      rdchk(OFS_INT_STATUS, 16'h0002);
      host.out_pkt(3'h0, 2, 1'b1);
      chk("nak reply", 16'h2, 16'(host.rep));
      wr(OFS_EP_FIRST, 16'h0003);
      host.out_pkt(3'h0, 8, 1'b1);
      chk("overrun reply", 16'h1, 16'(host.rep));
      rdchk(9'h142, 16'hbeef);
      rdchk(9'h123, 16'h0804);
      $display("receive test done");
   endtask
   task automatic t_tx;
      wr(9'h124, 16'h00a0);
      wr(9'h125, 16'h0003);
      wr(9'h150, 16'h2211);
      wr(9'h151, 16'hcc33);
      wr(9'h009, 16'h000c);
      host.in_pkt(3'h1, 3);
      for (int i = 0; i < 3; i++) begin
         chk("tx byte", 16'(8'h11 * (i + 1)), 16'(host.got[i]));
      end
      rdchk(9'h009, 16'h0108);
      host.out_pkt(3'h1, 2, 1'b1);
      chk("unused direction", 16'h0, 16'(host.rep));
      $display("transmit test done");
   endtask
   task automatic t_bus_reset;
      host.bus_reset();
      rdchk(OFS_EP_FIRST, 16'h0000);
      rdchk(9'h009, 16'h0100);
      rdchk(OFS_INT_STATUS, 16'h0003);
      host.out_pkt(3'h0, 2, 1'b1);
      chk("reply after bus reset", 16'h0, 16'(host.rep));
      wr(OFS_DEV_ADDR, 16'h0085);
      @(negedge i_clk);
      chk("device address", 16'h5, 16'(o_device_address));
      wr(OFS_EP_FIRST, 16'h0003);
      host.out_pkt(3'h0, 2, 1'b1);
      chk("endpoint zero back", 16'h4, 16'(host.rep));
      $display("bus reset test done");
   endtask

   initial begin
      repeat (16) @(posedge i_clk);
      i_rst <= 1'b0;
      t_bringup();
      t_rx();
      t_tx();
      t_bus_reset();
      tally_and_finish();
   end
   initial begin
      repeat (6000) @(posedge i_clk);
      fails++;
      tally_and_finish();
   end
endmodule
